// [logic/sci_pkg.sv]
package sci_pkg;
   // receive oversampling: one bit spans sixteen sub-ticks, voted at 7, 8 and 9
   localparam logic [3:0]  SUB_FIRST    = 4'h7;
   localparam logic [3:0]  SUB_MID      = 4'h9;
   localparam logic [3:0]  SUB_LAST     = 4'hF;
   // shared prescale factors picked by the two-bit field
   localparam logic [3:0]  PR_SEL0      = 4'h1;
   localparam logic [3:0]  PR_SEL1      = 4'h3;
   localparam logic [3:0]  PR_SEL2      = 4'h4;
   localparam logic [3:0]  PR_SEL3      = 4'hD;
   // last data bit index and whole frame length for 8 and 9 bit words
   localparam logic [3:0]  LAST_BIT_8   = 4'h7;
   localparam logic [3:0]  LAST_BIT_9   = 4'h8;
   localparam logic [3:0]  FRAME_LEN_8  = 4'hA;
   localparam logic [3:0]  FRAME_LEN_9  = 4'hB;
   // idle line: ten or eleven high bit times, in sub-ticks
   localparam logic [7:0]  IDLE_TICKS_8 = 8'hA0;
   localparam logic [7:0]  IDLE_TICKS_9 = 8'hB0;
   localparam logic [7:0]  FINE_OFF     = 8'h00;
   localparam int          FIFO_DEPTH   = 4;
   localparam int          WORD_W       = 9;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;

   typedef enum logic [0:0] {
      TX_IDLE  = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;

   typedef struct packed {
      logic tx_empty_flag;
      logic tx_done_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic overrun_flag;
      logic noise_flag;
      logic framing_fault_flag;
      logic parity_fault_flag;
   } status_t;

   localparam status_t STATUS_RESET = 8'hC0;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_irq_en;
      logic idle_irq_en;
      logic parity_irq_en;
      logic header_detect_irq_en;
   } irq_en_t;

   typedef struct packed {
      logic [1:0] shared_prescale_sel;
      logic [2:0] tx_rate_sel;
      logic [2:0] rx_rate_sel;
      logic [7:0] tx_fine_factor;
      logic [7:0] rx_fine_factor;
   } baud_cfg_t;

   typedef struct packed {
      logic word9;
      logic parity_enable;
      logic parity_odd_sel;
      logic wake_addr;
   } frame_cfg_t;
endpackage

// [logic/sci_rx_errors_baud_wakeup_parity.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - noise flag rises with receive-full, no own irq
// - noise and framing clear by status-then-data read
// - missing stop bit means framing fault
// - framing fault still transfers data, no irq
// - break shows as framing fault with zeros
// - rates are clock over sixteen, prescale, divisor
// - shared prescale one, three, four or thirteen
// - per-direction power-of-two divisor, one to 128
// - nonzero fine prescale divides further; zero bypasses
// - muted receiver sets no flags, no irqs
// - wake by idle line or address mark
// - idle wake clears mute, not idle flag
// - address mark wakes and word received normally
// - address mark uses data msb, not parity
// - frame formats follow word length and parity
// - parity makes ones count even or odd
// - transmit parity replaces data msb
// - parity mismatch sets fault, optional irq
// - wait mode unaffected, enabled irqs wake
// - halt freezes everything but the transmit buffer, which still takes writes; no halt exit
// - all events share one masked irq
// - word length bit picks eight or nine
// - parity sense changes only between characters
// - framing plus overrun sets only overrun

module sci_word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,       // core clock
   input  wire logic             rst_n,     // synchronised reset
   input  wire logic             in_valid,  // word offered
   input  wire logic [WIDTH-1:0] in_data,   // word in
   output logic                  in_ready,  // room for a word
   output logic                  out_valid, // word available
   output logic      [WIDTH-1:0] out_data,  // oldest word
   input  wire logic             out_ready  // consumer takes word
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        space;
   } fifo_state_t;

   fifo_state_t s_r;
   fifo_state_t s_nxt;
   logic        push;
   logic        pop;

   always_comb begin
      s_nxt = s_r;
      push  = in_valid && s_r.space;
      pop   = out_ready && (s_r.cnt != '0);
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp          = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt   = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      s_nxt.space = (s_nxt.cnt != FULL);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r       <= '0;
         s_r.space <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready  = s_r.space;
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rp];
endmodule

module sci_rx_errors_baud_wakeup_parity
   import sci_pkg::*;
(
   input  wire logic         core_clk,            // 50 MHz core clock
   input  wire logic         reset_n,             // async reset
   input  wire logic         rx_pin,              // serial receive line
   output logic              tx_pin,              // serial transmit line
   input  wire baud_cfg_t    baud_cfg,            // divider settings
   input  wire frame_cfg_t   frame_cfg,           // word length, parity, wake method
   input  wire irq_en_t      irq_en,              // per-event enables
   input  wire logic         tx_en,               // transmitter enable
   input  wire logic         rx_en,               // receiver enable
   input  wire logic         mute_wr,             // write strobe for mute bit
   input  wire logic         mute_wdata,          // value written to mute bit
   input  wire logic         header_detect_flag,  // header event from link logic
   input  wire logic         cpu_mask,            // cpu interrupt mask set
   input  wire logic         halt,                // halt mode
   input  wire logic         status_rd,           // status register read
   input  wire logic         data_rd,             // data register read
   input  wire logic         data_wr,             // data register write
   input  wire logic [8:0]   wr_data,             // word to transmit
   output logic              wr_ready,            // transmit buffer has room
   output status_t           status,              // status flags
   output logic      [8:0]   serial_data_reg,     // received word
   output logic              rx_mute_bit,         // receiver muted
   output logic              irq_req,             // shared interrupt request
   output logic              wake_req             // wait mode exit request
);
   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic [19:0] rx_cnt;
      logic [19:0] tx_cnt;
      rx_state_t   rx_st;
      logic [3:0]  rx_sub;
      logic [3:0]  rx_bit;
      logic [8:0]  rx_sh;
      logic [1:0]  rx_smp;
      logic        rx_noisy;
      logic        rx_word9;
      logic        rx_odd;
      logic [7:0]  idle_cnt;
      logic        idle_arm;
      tx_state_t   tx_st;
      logic [3:0]  tx_sub;
      logic [3:0]  tx_bit;
      logic [3:0]  tx_len;
      logic [10:0] tx_sh;
      logic        tx_odd;
      status_t     st;
      logic [8:0]  data;
      logic        mute;
      logic        armed;
      logic        irq;
      logic        wake;
      logic        tx_pin;
   } core_state_t;

   core_state_t s_r;
   core_state_t s_nxt;
   logic        rst_q1;
   logic        rst_q2;
   logic        rst_n;
   logic        f_valid;
   logic [8:0]  f_data;
   logic        pop;
   logic        rx_tick;
   logic        tx_tick;
   logic [2:0]  vote;
   logic        maj;
   logic        noisy;
   logic        done;
   logic        stop_low;
   logic [8:0]  rx_word;
   logic        msb;
   logic        par_bad;
   logic        accept;
   logic [7:0]  idle_lim;
   logic [8:0]  td;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end
   assign rst_n = rst_q2;

   // decoupling the writer from frame timing; a write to a full buffer is dropped
   sci_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .clk       (core_clk),
      .rst_n     (rst_n),
      .in_valid  (data_wr),
      .in_data   (wr_data),
      .in_ready  (wr_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (pop)
   );

   function automatic logic [19:0] div_len(input logic [1:0] p, input logic [2:0] r,
                                           input logic [7:0] f);
      logic [3:0]  pr;
      logic [19:0] base;
      case (p)
         2'h0:    pr = PR_SEL0;
         2'h1:    pr = PR_SEL1;
         2'h2:    pr = PR_SEL2;
         default: pr = PR_SEL3;
      endcase
      base    = 20'(pr) << r;
      div_len = base * 20'((f == FINE_OFF) ? 8'h01 : f);
   endfunction

   always_comb begin
      s_nxt    = s_r;
      pop      = 1'b0;
      done     = 1'b0;
      stop_low = 1'b0;
      s_nxt.sync1 = rx_pin;
      s_nxt.sync2 = s_r.sync1;

      // sub-tick enables at sixteen times each bit rate
      rx_tick = (s_r.rx_cnt == 20'h00000);
      tx_tick = (s_r.tx_cnt == 20'h00000);
      s_nxt.rx_cnt = rx_tick ? div_len(baud_cfg.shared_prescale_sel, baud_cfg.rx_rate_sel,
                                       baud_cfg.rx_fine_factor) - 20'h00001
                             : s_r.rx_cnt - 20'h00001;
      s_nxt.tx_cnt = tx_tick ? div_len(baud_cfg.shared_prescale_sel, baud_cfg.tx_rate_sel,
                                       baud_cfg.tx_fine_factor) - 20'h00001
                             : s_r.tx_cnt - 20'h00001;

      vote  = {s_r.rx_smp, s_r.sync2};
      maj   = (vote[0] & vote[1]) | (vote[0] & vote[2]) | (vote[1] & vote[2]);
      noisy = (|vote) && !(&vote);

      if (rx_en && rx_tick) begin
         if (s_r.rx_st == RX_IDLE) begin
            // level start, so a start bit right behind a low stop is still caught
            if (!s_r.sync2) begin
               s_nxt.rx_st    = RX_START;
               s_nxt.rx_sub   = 4'h0;
               s_nxt.rx_bit   = 4'h0;
               s_nxt.rx_noisy = 1'b0;
               s_nxt.rx_word9 = frame_cfg.word9;
               s_nxt.rx_odd   = frame_cfg.parity_odd_sel;
            end
         end else begin
            s_nxt.rx_sub = s_r.rx_sub + 4'h1;
            if (s_r.rx_sub >= SUB_FIRST && s_r.rx_sub < SUB_MID) begin
               s_nxt.rx_smp = {s_r.rx_smp[0], s_r.sync2};
            end
            if (s_r.rx_sub == SUB_MID) begin
               case (s_r.rx_st)
                  RX_START: begin
                     if (maj) begin
                        s_nxt.rx_st = RX_IDLE;
                     end
                  end
                  RX_DATA: begin
                     s_nxt.rx_sh    = {maj, s_r.rx_sh[8:1]};
                     s_nxt.rx_noisy = s_r.rx_noisy | noisy;
                  end
                  RX_STOP: begin
                     done        = 1'b1;
                     stop_low    = !maj;
                     s_nxt.rx_st = RX_IDLE;
                  end
                  default: begin
                  end
               endcase
            end
            if (s_r.rx_sub == SUB_LAST) begin
               if (s_r.rx_st == RX_START) begin
                  s_nxt.rx_st = RX_DATA;
               end else if (s_r.rx_st == RX_DATA) begin
                  s_nxt.rx_bit = s_r.rx_bit + 4'h1;
                  if (s_r.rx_bit == (s_r.rx_word9 ? LAST_BIT_9 : LAST_BIT_8)) begin
                     s_nxt.rx_st = RX_STOP;
                  end
               end
            end
         end
      end
      if (!rx_en) begin
         s_nxt.rx_st = RX_IDLE;
      end

      // software access sequence; hardware sets further down win over these clears
      if (status_rd) begin
         s_nxt.armed = 1'b1;
      end
      if (data_rd && s_r.armed) begin
         s_nxt.st.rx_full_flag       = 1'b0;
         s_nxt.st.idle_flag          = 1'b0;
         s_nxt.st.overrun_flag       = 1'b0;
         s_nxt.st.noise_flag         = 1'b0;
         s_nxt.st.framing_fault_flag = 1'b0;
         s_nxt.st.parity_fault_flag  = 1'b0;
         s_nxt.armed                 = 1'b0;
      end
      if (data_wr && s_r.armed) begin
         s_nxt.st.tx_empty_flag = 1'b0;
         s_nxt.st.tx_done_flag  = 1'b0;
         s_nxt.armed            = 1'b0;
      end

      // word completion
      rx_word = s_r.rx_word9 ? s_r.rx_sh : {1'b0, s_r.rx_sh[8:1]};
      if (frame_cfg.parity_enable) begin
         msb = s_r.rx_word9 ? rx_word[7] : rx_word[6];
      end else begin
         msb = s_r.rx_word9 ? rx_word[8] : rx_word[7];
      end
      par_bad = frame_cfg.parity_enable && ((^rx_word) != s_r.rx_odd);
      accept  = !s_r.mute || (frame_cfg.wake_addr && msb);
      if (done && accept) begin
         s_nxt.mute = 1'b0;
         if (s_r.st.rx_full_flag) begin
            s_nxt.st.overrun_flag = 1'b1;
         end else begin
            s_nxt.data                  = rx_word;
            s_nxt.st.rx_full_flag       = 1'b1;
            s_nxt.st.noise_flag         = s_r.rx_noisy | noisy;
            s_nxt.st.framing_fault_flag = stop_low;
            s_nxt.st.parity_fault_flag  = par_bad;
            s_nxt.idle_arm              = 1'b1;
         end
      end

      // idle line: counts only in idle state with the line high
      idle_lim = frame_cfg.word9 ? IDLE_TICKS_9 : IDLE_TICKS_8;
      if (rx_en && rx_tick) begin
         if (s_r.rx_st == RX_IDLE && s_r.sync2) begin
            if (s_r.idle_cnt != idle_lim) begin
               s_nxt.idle_cnt = s_r.idle_cnt + 8'h01;
               if (s_nxt.idle_cnt == idle_lim) begin
                  if (s_r.mute) begin
                     if (!frame_cfg.wake_addr) begin
                        s_nxt.mute = 1'b0;
                     end
                  end else if (s_r.idle_arm) begin
                     s_nxt.st.idle_flag = 1'b1;
                     s_nxt.idle_arm     = 1'b0;
                  end
               end
            end
         end else begin
            s_nxt.idle_cnt = 8'h00;
         end
      end
      if (mute_wr) begin
         s_nxt.mute = mute_wdata;
      end

      // transmitter
      td = f_data;
      if (frame_cfg.parity_enable) begin
         if (frame_cfg.word9) begin
            td[8] = (^f_data[7:0]) ^ frame_cfg.parity_odd_sel;
         end else begin
            td[7] = (^f_data[6:0]) ^ frame_cfg.parity_odd_sel;
         end
      end
      if (s_r.tx_st == TX_IDLE) begin
         s_nxt.tx_pin = 1'b1;
         if (tx_en && f_valid) begin
            pop                    = 1'b1;
            s_nxt.tx_st            = TX_SHIFT;
            s_nxt.tx_sub           = 4'h0;
            s_nxt.tx_bit           = 4'h0;
            s_nxt.tx_odd           = frame_cfg.parity_odd_sel;
            s_nxt.tx_len           = frame_cfg.word9 ? FRAME_LEN_9 : FRAME_LEN_8;
            s_nxt.tx_sh            = frame_cfg.word9 ? {1'b1, td, 1'b0}
                                                     : {2'b11, td[7:0], 1'b0};
            s_nxt.tx_pin           = 1'b0;
            s_nxt.st.tx_empty_flag = 1'b1;
         end
      end else if (tx_tick) begin
         s_nxt.tx_sub = s_r.tx_sub + 4'h1;
         if (s_r.tx_sub == SUB_LAST) begin
            s_nxt.tx_sh  = {1'b1, s_r.tx_sh[10:1]};
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            s_nxt.tx_pin = s_r.tx_sh[1];
            if (s_r.tx_bit == s_r.tx_len - 4'h1) begin
               s_nxt.tx_st           = TX_IDLE;
               s_nxt.tx_pin          = 1'b1;
               s_nxt.st.tx_done_flag = 1'b1;
            end
         end
      end
      if (!tx_en) begin
         s_nxt.tx_st  = TX_IDLE;
         s_nxt.tx_pin = 1'b1;
      end

      // one shared request; noise and framing have no enable of their own
      s_nxt.irq = !cpu_mask && (
         (irq_en.tx_empty_irq_en && s_nxt.st.tx_empty_flag) ||
         (irq_en.tx_done_irq_en && s_nxt.st.tx_done_flag) ||
         (!s_nxt.mute && irq_en.rx_irq_en &&
          (s_nxt.st.rx_full_flag || s_nxt.st.overrun_flag)) ||
         (!s_nxt.mute && irq_en.idle_irq_en && s_nxt.st.idle_flag) ||
         (!s_nxt.mute && irq_en.parity_irq_en && s_nxt.st.parity_fault_flag) ||
         (irq_en.header_detect_irq_en && header_detect_flag));
      s_nxt.wake = s_nxt.irq;

      if (halt) begin
         pop        = 1'b0;
         s_nxt      = s_r;
         s_nxt.wake = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r        <= '0;
         s_r.sync1  <= 1'b1;
         s_r.sync2  <= 1'b1;
         s_r.st     <= STATUS_RESET;
         s_r.tx_pin <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tx_pin          = s_r.tx_pin;
   assign status          = s_r.st;
   assign serial_data_reg = s_r.data;
   assign rx_mute_bit     = s_r.mute;
   assign irq_req         = s_r.irq;
   assign wake_req        = s_r.wake;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_noise_with_full: assert property (
      $rose(s_r.st.noise_flag) |-> $rose(s_r.st.rx_full_flag))
      else $error("noise flag rose without receive-full");
   a_noise_clear_seq: assert property (
      $fell(s_r.st.noise_flag) |-> $past(data_rd) && $past(s_r.armed))
      else $error("noise flag cleared outside the read sequence");
   a_framing_with_full: assert property (
      $rose(s_r.st.framing_fault_flag) |-> $rose(s_r.st.rx_full_flag))
      else $error("framing flag rose without receive-full");
   a_overrun_no_frame: assert property (
      $rose(s_r.st.overrun_flag) |-> !$rose(s_r.st.framing_fault_flag)
                                     && $stable(s_r.data))
      else $error("overrun also raised framing or lost data");
   a_idle_wake_quiet: assert property (
      $fell(s_r.mute) && !$past(mute_wr) && !$past(frame_cfg.wake_addr)
      |-> !$rose(s_r.st.idle_flag))
      else $error("idle wake set the idle flag");
   a_addr_wake_full: assert property (
      $fell(s_r.mute) && !$past(mute_wr) && $past(frame_cfg.wake_addr)
      |-> $rose(s_r.st.rx_full_flag) || $rose(s_r.st.overrun_flag))
      else $error("address wake did not receive the word");
   a_mask_blocks_irq: assert property (
      cpu_mask && !halt |=> !irq_req)
      else $error("interrupt raised while cpu mask set");
   a_halt_freeze: assert property (
      halt |=> $stable(s_r.st) && $stable(s_r.tx_sh) && $stable(s_r.rx_st) && !wake_req)
      else $error("state moved or wake raised in halt");
   a_tx_parity: assert property (
      $rose(s_r.tx_st == TX_SHIFT) && $past(frame_cfg.parity_enable)
      && !$past(frame_cfg.word9) |-> (^s_r.tx_sh[8:1]) == s_r.tx_odd)
      else $error("transmit parity bit wrong");
endmodule

// [tb/serial_node.sv]
`timescale 1ns/100ps
module serial_node (
   input  wire logic clk,      // core clock
   input  wire logic line_in,  // device transmit line
   output logic      line_out  // device receive line, idle high
);
   int bit_clks = 16;
   // data bit index that gets a one-clock glitch, -1 for none; assumes sixteen clocks a bit
   int glitch_bit = -1;
   initial line_out = 1'b1;
   // stop level is a parameter of the call so faults can be sent on purpose
   task automatic send(input logic [8:0] w, input int n, input logic stop);
      line_out <= 1'b0;
      repeat (bit_clks) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         line_out <= w[i];
         if (i == glitch_bit) begin
            // flips only the middle vote sample, so the majority still recovers the bit
            repeat (9) @(negedge clk);
            line_out <= ~w[i];
            @(negedge clk);
            line_out <= w[i];
            repeat (bit_clks - 10) @(negedge clk);
         end else begin
            repeat (bit_clks) @(negedge clk);
         end
      end
      line_out <= stop;
      repeat (bit_clks) @(negedge clk);
      line_out <= 1'b1;
      repeat (2 * bit_clks) @(negedge clk);
   endtask
   task automatic recv(input int n, output logic [8:0] w);
      w = '0;
      wait (line_in === 1'b0);
      repeat (bit_clks / 2) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         repeat (bit_clks) @(negedge clk);
         w[i] = line_in;
      end
   endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
   import sci_pkg::*;
   logic       core_clk, reset_n, rx_pin, tx_pin, tx_en, rx_en, mute_wr, mute_wdata;
   logic       hdr, cpu_mask, halt, status_rd, data_rd, data_wr, wr_ready;
   logic       rx_mute_bit, irq_req, wake_req;
   logic [8:0] wr_data, serial_data_reg, got;
   baud_cfg_t  baud_cfg;
   frame_cfg_t frame_cfg;
   irq_en_t    irq_en;
   status_t    status;
   int         errors, tests_run, cycles;

   sci_rx_errors_baud_wakeup_parity dut (.core_clk(core_clk), .reset_n(reset_n),
      .rx_pin(rx_pin), .tx_pin(tx_pin), .baud_cfg(baud_cfg), .frame_cfg(frame_cfg),
      .irq_en(irq_en), .tx_en(tx_en), .rx_en(rx_en), .mute_wr(mute_wr),
      .mute_wdata(mute_wdata), .header_detect_flag(hdr), .cpu_mask(cpu_mask),
      .halt(halt), .status_rd(status_rd), .data_rd(data_rd), .data_wr(data_wr),
      .wr_data(wr_data), .wr_ready(wr_ready), .status(status),
      .serial_data_reg(serial_data_reg), .rx_mute_bit(rx_mute_bit),
      .irq_req(irq_req), .wake_req(wake_req));
   serial_node node (.clk(core_clk), .line_in(tx_pin), .line_out(rx_pin));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // longest run is near 6k cycles; the ceiling leaves ample margin
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         final_report();
      end
   end

   task automatic final_report();
      if (errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic clr_rx();
      status_rd = 1'b1;
      tick(1);
      status_rd = 1'b0;
      data_rd = 1'b1;
      tick(1);
      data_rd = 1'b0;
      tick(1);
   endtask
   task automatic mute();
      mute_wr = 1'b1;
      mute_wdata = 1'b1;
      tick(1);
      mute_wr = 1'b0;
      tick(1);
   endtask

   initial begin
      {reset_n, tx_en, rx_en, mute_wr, mute_wdata, hdr, cpu_mask, halt} = '0;
      {status_rd, data_rd, data_wr, wr_data, frame_cfg, irq_en, baud_cfg} = '0;
      tick(5);
      reset_n = 1'b1;
      tick(3);
      chk(status, STATUS_RESET);
      chk(tx_pin, 1'b1);
      chk(wr_ready, 1'b1);
      rx_en = 1'b1;
      tx_en = 1'b1;
      irq_en = 6'h08;
      node.glitch_bit = 2;
      node.send(9'h0A5, 8, 1'b1);
      node.glitch_bit = -1;
      chk(status.rx_full_flag, 1'b1);
      chk(status.noise_flag, 1'b1);
      chk(serial_data_reg, 9'h0A5);
      chk(irq_req, 1'b1);
      clr_rx();
      chk(status.rx_full_flag, 1'b0);
      chk(status.noise_flag, 1'b0);
      node.send(9'h03C, 8, 1'b0);
      chk(status.framing_fault_flag, 1'b1);
      chk(serial_data_reg, 9'h03C);
      data_rd = 1'b1;
      tick(1);
      data_rd = 1'b0;
      tick(1);
      chk(status.framing_fault_flag, 1'b1);
      clr_rx();
      chk(status.framing_fault_flag, 1'b0);
      node.send(9'h000, 8, 1'b0);
      chk({status.framing_fault_flag, serial_data_reg}, 10'h200);
      clr_rx();
      node.send(9'h011, 8, 1'b1);
      node.send(9'h022, 8, 1'b0);
      chk({status.overrun_flag, status.framing_fault_flag}, 2'b10);
      chk(serial_data_reg, 9'h011);
      clr_rx();
      irq_en = 6'h02;
      for (int odd = 0; odd < 2; odd++) begin
         frame_cfg = '{word9: 1'b0, parity_enable: 1'b1, parity_odd_sel: odd[0], wake_addr: 1'b0};
         // 35h has four ones: even parity bit 0, odd parity bit 1
         node.send({1'b0, ~odd[0], 7'h35}, 8, 1'b1);
         chk(status.parity_fault_flag, 1'b1);
         chk(irq_req, 1'b1);
         cpu_mask = 1'b1;
         tick(2);
         chk(irq_req, 1'b0);
         cpu_mask = 1'b0;
         clr_rx();
         node.send({1'b0, odd[0], 7'h35}, 8, 1'b1);
         chk(status.parity_fault_flag, 1'b0);
         clr_rx();
         status_rd = 1'b1;
         tick(1);
         status_rd = 1'b0;
         wr_data = 9'h0B5;
         data_wr = 1'b1;
         tick(1);
         data_wr = 1'b0;
         chk({status.tx_empty_flag, status.tx_done_flag}, 2'b00);
         node.recv(8, got);
         chk(got, {1'b0, odd[0], 7'h35});
         tick(48);
         chk({status.tx_empty_flag, status.tx_done_flag}, 2'b11);
      end
      for (int pe = 0; pe < 2; pe++) begin
         frame_cfg = '{word9: 1'b0, parity_enable: pe[0], parity_odd_sel: 1'b0, wake_addr: 1'b1};
         mute();
         chk(rx_mute_bit, 1'b1);
         node.send(pe ? 9'h080 : 9'h012, 8, 1'b1);
         chk({rx_mute_bit, status.rx_full_flag}, 2'b10);
         node.send(pe ? 9'h0C0 : 9'h092, 8, 1'b1);
         chk({rx_mute_bit, status.rx_full_flag}, 2'b01);
         clr_rx();
      end
      frame_cfg = '0;
      mute();
      node.send(9'h055, 8, 1'b1);
      chk(rx_mute_bit, 1'b1);
      tick(200);
      chk({rx_mute_bit, status.idle_flag, status.rx_full_flag}, 3'b000);
      frame_cfg.word9 = 1'b1;
      node.send(9'h1A5, 9, 1'b1);
      chk(serial_data_reg, 9'h1A5);
      clr_rx();
      frame_cfg = '0;
      {rx_en, tx_en} = 2'b00;
      tick(1);
      baud_cfg = '{shared_prescale_sel: 2'h1, tx_rate_sel: 3'h0, rx_rate_sel: 3'h1,
                   tx_fine_factor: 8'h00, rx_fine_factor: 8'h02};
      node.bit_clks = 16 * 3 * 2 * 2;
      tick(1);
      rx_en = 1'b1;
      node.send(9'h0C3, 8, 1'b1);
      chk(serial_data_reg, 9'h0C3);
      clr_rx();
      irq_en = 6'h01;
      hdr = 1'b1;
      tick(2);
      chk({irq_req, wake_req}, 2'b11);
      halt = 1'b1;
      tick(2);
      chk({irq_req, wake_req}, 2'b10);
      final_report();
   end
endmodule
